/* gpio_link_device.sv */
// pin data/direction/enable registers behind the serial link
`timescale 1ns/1ps
module gpio_link_device #(
	parameter int PIN_COUNT = 8
) (
	gpio_link_if.device link,
	input wire logic reset,
	input wire logic [gpio_link_pkg::DATA_W-1:0] pin_in,
	output logic [gpio_link_pkg::DATA_W-1:0] pin_out,
	output logic [gpio_link_pkg::DATA_W-1:0] pin_oe,
	output logic [gpio_link_pkg::DATA_W-1:0] pin_enable_bits,
	output logic [gpio_link_pkg::DATA_W-1:0] pin_direction_bits,
	output logic [gpio_link_pkg::DATA_W-1:0] pin_level_bits
);
	import gpio_link_pkg::*;

	initial
	begin
		if (PIN_COUNT != 4 && PIN_COUNT != 8)
			$error("PIN_COUNT must be 4 or 8");
	end

	logic [4:0] bit_cnt_reg;
	logic [FRAME_BITS-2:0] shift_in_reg;
	logic [DATA_W-1:0] enable_reg;
	logic [DATA_W-1:0] direction_reg;
	logic [DATA_W-1:0] level_reg;
	logic [DATA_W-1:0] sync1_reg;
	logic [DATA_W-1:0] sync2_reg;
	logic miso_reg;
	logic [DATA_W-2:0] tx_reg;

	// four-pin variant stores low nibble only
	wire [DATA_W-1:0] pin_mask = (PIN_COUNT == 4) ? MASK_FOUR : MASK_EIGHT;
	wire [FRAME_BITS-1:0] frame_word = {shift_in_reg, link.mosi};
	wire [DATA_W-1:0] cmd_byte = frame_word[FRAME_BITS-1:DATA_W];
	wire [DATA_W-1:0] wr_byte = frame_word[DATA_W-1:0] & pin_mask;
	wire [ADDR_W-1:0] wr_addr = cmd_byte[ADDR_W-1:0];
	wire last_fall = (bit_cnt_reg == 5'(FRAME_BITS - 1));
	wire wr_go = last_fall && cmd_byte[CMD_WRITE_POS];
	wire [ADDR_W-1:0] rd_addr = shift_in_reg[ADDR_W-1:0];
	// output reads register, input reads pin
	wire [DATA_W-1:0] level_view = ((direction_reg & sync2_reg) | (~direction_reg & level_reg))
		& pin_mask;
	wire [DATA_W-1:0] rd_byte = (rd_addr == REG_PIN_ENABLE) ? enable_reg :
		(rd_addr == REG_PIN_DIRECTION) ? direction_reg :
		(rd_addr == REG_PIN_LEVEL) ? level_view : REG_RESET;

	// sample incoming bits on falling edge
	always_ff @(negedge link.sclk or posedge reset or posedge link.cs_n)
	begin
		if (reset || link.cs_n)
		begin
			bit_cnt_reg <= 5'h00;
			shift_in_reg <= '0;
		end
		else
		begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
			shift_in_reg <= frame_word[FRAME_BITS-2:0];
		end
	end

	always_ff @(negedge link.sclk or posedge reset)
	begin
		if (reset)
		begin
			enable_reg <= REG_RESET;
			direction_reg <= REG_RESET;
			level_reg <= REG_RESET;
		end
		else if (wr_go && !link.cs_n)
		begin
			if (wr_addr == REG_PIN_ENABLE)
				enable_reg <= wr_byte;
			if (wr_addr == REG_PIN_DIRECTION)
				direction_reg <= wr_byte;
			// write to input pin stores only
			if (wr_addr == REG_PIN_LEVEL)
				level_reg <= wr_byte;
		end
	end

	always_ff @(posedge link.sclk or posedge reset)
	begin
		if (reset)
		begin
			sync1_reg <= REG_RESET;
			sync2_reg <= REG_RESET;
		end
		else
		begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	// launch reply bits on rising edge
	always_ff @(posedge link.sclk or posedge reset or posedge link.cs_n)
	begin
		if (reset || link.cs_n)
		begin
			miso_reg <= 1'b0;
			tx_reg <= '0;
		end
		else if (bit_cnt_reg == 5'(DATA_W))
		begin
			miso_reg <= rd_byte[DATA_W-1];
			tx_reg <= rd_byte[DATA_W-2:0];
		end
		else if (bit_cnt_reg > 5'(DATA_W))
		begin
			miso_reg <= tx_reg[DATA_W-2];
			tx_reg <= {tx_reg[DATA_W-3:0], 1'b0};
		end
	end

	assign link.miso_o = miso_reg;
	assign link.miso_oe = !link.cs_n;
	// enabled output pins driven from data
	assign pin_out = level_reg;
	assign pin_oe = enable_reg & ~direction_reg;
	assign pin_enable_bits = enable_reg;
	assign pin_direction_bits = direction_reg;
	assign pin_level_bits = level_reg;
endmodule

/* gpio_link_host.sv */
// serial link master issuing register reads and writes
`timescale 1ns/1ps
module gpio_link_host #(
	parameter int HALF_CYCLES = gpio_link_pkg::SCLK_HALF_CYCLES,
	parameter int PIN_COUNT = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	gpio_link_if.host link,
	input wire logic req,
	input wire logic req_write,
	input wire logic [gpio_link_pkg::ADDR_W-1:0] req_addr,
	input wire logic [gpio_link_pkg::DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic done,
	output logic [gpio_link_pkg::DATA_W-1:0] rdata
);
	import gpio_link_pkg::*;

	initial
	begin
		if (HALF_CYCLES < MISO_SYNC_MIN || HALF_CYCLES > 255)
			$error("HALF_CYCLES must be 3 to 255");
		if (PIN_COUNT != 4 && PIN_COUNT != 8)
			$error("PIN_COUNT must be 4 or 8");
	end

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LEAD = 5'b00010,
		ST_HIGH = 5'b00100,
		ST_LOW = 5'b01000,
		ST_TRAIL = 5'b10000
	} host_state_t;

	host_state_t state_reg;
	logic [7:0] div_reg;
	logic [4:0] bits_reg;
	logic [FRAME_BITS-1:0] tx_reg;
	logic [DATA_W-1:0] rx_reg;
	logic sclk_reg;
	logic cs_n_reg;
	logic mosi_reg;
	logic done_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic miso_s1_reg;
	logic miso_s2_reg;

	wire half_done = (div_reg == 8'(HALF_CYCLES - 1));
	wire last_bit = (bits_reg == 5'(FRAME_BITS - 1));
	wire [DATA_W-1:0] cmd_byte = {req_write, {(DATA_W-ADDR_W-1){1'b0}}, req_addr};
	wire [DATA_W-1:0] data_mask = (PIN_COUNT == 4) ? MASK_FOUR : MASK_EIGHT;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			miso_s1_reg <= 1'b1;
			miso_s2_reg <= 1'b1;
		end
		else
		begin
			miso_s1_reg <= link.miso;
			miso_s2_reg <= miso_s1_reg;
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			div_reg <= 8'h00;
		else if (state_reg == ST_IDLE || half_done)
			div_reg <= 8'h00;
		else
			div_reg <= div_reg + 8'h01;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= ST_IDLE;
			bits_reg <= 5'h00;
			tx_reg <= '0;
			rx_reg <= '0;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			mosi_reg <= 1'b0;
			done_reg <= 1'b0;
			rdata_reg <= '0;
		end
		else
		begin
			done_reg <= 1'b0;
			unique case (state_reg)
				ST_IDLE:
				begin
					if (req)
					begin
						tx_reg <= {cmd_byte, req_wdata & data_mask};
						bits_reg <= 5'h00;
						cs_n_reg <= 1'b0;
						state_reg <= ST_LEAD;
					end
				end
				ST_LEAD:
				begin
					if (half_done)
					begin
						sclk_reg <= 1'b1;
						mosi_reg <= tx_reg[FRAME_BITS-1];
						tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
						state_reg <= ST_HIGH;
					end
				end
				ST_HIGH:
				begin
					if (half_done)
					begin
						sclk_reg <= 1'b0;
						rx_reg <= {rx_reg[DATA_W-2:0], miso_s2_reg};
						state_reg <= last_bit ? ST_TRAIL : ST_LOW;
						bits_reg <= bits_reg + 5'h01;
					end
				end
				ST_LOW:
				begin
					if (half_done)
					begin
						sclk_reg <= 1'b1;
						mosi_reg <= tx_reg[FRAME_BITS-1];
						tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
						state_reg <= ST_HIGH;
					end
				end
				ST_TRAIL:
				begin
					if (half_done)
					begin
						cs_n_reg <= 1'b1;
						mosi_reg <= 1'b0;
						done_reg <= 1'b1;
						rdata_reg <= rx_reg;
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	assign link.sclk = sclk_reg;
	assign link.cs_n = cs_n_reg;
	assign link.mosi = mosi_reg;
	assign req_ready = (state_reg == ST_IDLE);
	assign done = done_reg;
	assign rdata = rdata_reg;
endmodule

/* gpio_link_if.sv */
// serial link wires between host and pin register device
`timescale 1ns/1ps
interface gpio_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;
	// released line pulled high
	assign miso = miso_oe ? miso_o : 1'b1;
	modport device (input sclk, input cs_n, input mosi, output miso_o, output miso_oe);
	modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

/* gpio_link_pkg.sv */
// constants shared by both ends of the pin register link
package gpio_link_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int FRAME_BITS = 16;
	localparam int CMD_WRITE_POS = 7;
	localparam logic [ADDR_W-1:0] REG_PIN_ENABLE = 4'hc;
	localparam logic [ADDR_W-1:0] REG_PIN_DIRECTION = 4'hd;
	localparam logic [ADDR_W-1:0] REG_PIN_LEVEL = 4'he;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] MASK_FOUR = 8'h0f;
	localparam logic [DATA_W-1:0] MASK_EIGHT = 8'hff;
	localparam int CLK_SYS_NS = 20;
	localparam int SCLK_HALF_NS = 80;
	localparam int SCLK_HALF_CYCLES = SCLK_HALF_NS / CLK_SYS_NS;
	localparam int MISO_SYNC_MIN = 3;
endpackage

/* gpio_link_properties.sv */
// link timing properties
`timescale 1ns/1ps
module gpio_link_properties (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic miso
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_sclk_idle_low: assert property (cs_n |-> !sclk) else $error("sclk busy");
	chk_mosi_hold: assert property (sclk && $past(sclk) && !cs_n |-> $stable(mosi))
		else $error("mosi moved");
	chk_reply_hold: assert property (sclk && $past(sclk) && !cs_n |-> $stable(miso_o))
		else $error("reply moved");
	chk_drive_sel: assert property (miso_oe == !cs_n) else $error("oe wrong");
	chk_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("high half");
	chk_low_half: assert property ($fell(sclk) |-> !sclk[*4]) else $error("low half");
	chk_lead_time: assert property ($fell(cs_n) |-> !sclk[*4] ##1 sclk)
		else $error("lead time");
	chk_frame_len: assert property ($fell(cs_n) |-> ##132 $rose(cs_n))
		else $error("frame len");
	chk_cmd_quiet: assert property ($fell(cs_n) |-> !miso_o throughout ##67 1'b1)
		else $error("reply early");
	cover property ($rose(miso_o));
	cover property ($fell(cs_n));
	cover property (!cs_n && !miso);
endmodule

/* tb_adc_gpio_data_register.sv */
// bench for both link ends, eight- and four-pin
`timescale 1ns/1ps
module tb_adc_gpio_data_register;
	import gpio_link_pkg::*;
	logic clk_sys = 0;
	logic reset = 1;
	logic req = 0;
	logic req_write = 0;
	logic [3:0] req_addr = 0;
	logic [7:0] req_wdata = 0;
	logic [7:0] pin_in = 0;
	logic [7:0] rd8, rd4, out8, oe8, out4, oe4, lv8;
	logic dn8, rdy8;
	logic [15:0] sh, rx, sh4;
	logic [31:0] seed = 32'hb8e191df;
	logic [2:0][7:0] m8 = '0;
	logic [2:0][7:0] m4 = '0;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	gpio_link_if l8();
	gpio_link_if l4();
	gpio_link_host u_gpio_link_host (.clk_sys(clk_sys), .reset(reset), .link(l8.host),
		.req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(rdy8), .done(dn8), .rdata(rd8));
	gpio_link_host #(.PIN_COUNT(4)) u_gpio_link_host_four (.clk_sys(clk_sys),
		.reset(reset), .link(l4.host), .req(req), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(), .done(), .rdata(rd4));
	gpio_link_device #(.PIN_COUNT(8)) u_gpio_link_device (.link(l8.device), .reset(reset),
		.pin_in(pin_in), .pin_out(out8), .pin_oe(oe8), .pin_enable_bits(),
		.pin_direction_bits(), .pin_level_bits(lv8));
	gpio_link_device #(.PIN_COUNT(4)) u_gpio_link_device_four (.link(l4.device),
		.reset(reset), .pin_in(pin_in), .pin_out(out4), .pin_oe(oe4), .pin_enable_bits(),
		.pin_direction_bits(), .pin_level_bits());
	gpio_link_properties u_gpio_link_properties (.clk_sys(clk_sys), .reset(reset),
		.sclk(l8.sclk), .cs_n(l8.cs_n), .mosi(l8.mosi), .miso_o(l8.miso_o),
		.miso_oe(l8.miso_oe), .miso(l8.miso));
	initial
	begin
		forever #10 clk_sys = ~clk_sys;
	end
	always @(negedge l8.sclk)
	begin
		sh = {sh[14:0], l8.mosi};
		rx = {rx[14:0], l8.miso};
	end
	always @(negedge l4.sclk)
	begin
		sh4 = {sh4[14:0], l4.mosi};
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			finish_test;
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [7:0] view(input logic [3:0] a, input logic [2:0][7:0] m,
		input logic [7:0] p);
		if (a == REG_PIN_LEVEL)
			return (m[1] & p) | (~m[1] & m[2]);
		return (a < REG_PIN_ENABLE || a > REG_PIN_LEVEL) ? 8'h00 : m[a[1:0]];
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
		logic [7:0] e8, e4;
		int n;
		e8 = view(a, m8, pin_in);
		e4 = view(a, m4, pin_in);
		n = 0;
		@(posedge clk_sys);
		#1;
		chk(dn8, 0);
		chk(rdy8, 1);
		req = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(posedge clk_sys);
		#1;
		req = 0;
		chk(rdy8, 0);
		while (dn8 !== 1'b1 && n < 300)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (w && a >= REG_PIN_ENABLE && a <= REG_PIN_LEVEL)
		begin
			m8[a[1:0]] = d;
			m4[a[1:0]] = d & MASK_FOUR;
		end
		chk(16'(n), 16'((2 * FRAME_BITS + 1) * SCLK_HALF_CYCLES));
		chk(sh, {w, 3'h0, a, d});
		chk(sh4, {w, 3'h0, a, d & MASK_FOUR});
		chk(rx, {8'h00, e8});
		chk(rd8, e8);
		chk(rd4, e4);
		chk(out8, m8[2]);
		chk(lv8, m8[2]);
		chk(out4, m4[2]);
		chk(oe8, m8[0] & ~m8[1]);
		chk(oe4, m4[0] & ~m4[1]);
	endtask
	task automatic finish_test;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_sys);
		#1;
		reset = 0;
		for (int i = 0; i < 3; i++)
			xfer(0, {2'h3, i[1:0]}, 8'h00);
		xfer(1, REG_PIN_LEVEL, 8'hff);
		xfer(1, REG_PIN_ENABLE, 8'hff);
		xfer(1, REG_PIN_DIRECTION, 8'h0f);
		pin_in = 8'ha5;
		xfer(1, REG_PIN_LEVEL, 8'h00);
		xfer(1, 4'hf, 8'h55);
		repeat (60)
		begin
			seed = xs(seed);
			pin_in = seed[15:8];
			xfer(seed[16], seed[1:0] == 2'h3 ? seed[7:4] : {2'h3, seed[1:0]}, seed[31:24]);
		end
		finish_test;
	end
endmodule
